// ===== rtl/cbt_training.sv
// device side of command bus training, second mode
`include "cbt_regs.svh"
`default_nettype none
module cbt_training (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // data strobe, clock of the capture domain
  input wire logic clk_strobe,
  // command pins from the controller
  input wire cbt_pkg::cbt_cmd_type cmd_pins,
  // mode register state, same clock
  input wire logic training_enable_bit,
  input wire logic active_frequency_set_point_setting,
  // data pins
  input wire logic [7:0] dq_in,
  output cbt_pkg::cbt_dq_drive_type dq_drive,
  input wire logic dmi_in,
  output logic dmi_out,
  output logic dmi_oe,
  // status toward the rest of the die
  output logic command_decode_enable,
  output logic active_frequency_set_point,
  output cbt_pkg::cbt_vref_type ca_reference_voltage,
  output logic device_ready
);
  import cbt_pkg::*;

  localparam logic [3:0] HIZ_GAP = 4'(`CBT_HIZ_GAP_CYCLES);
  localparam logic [3:0] MRW_WAIT = 4'(`CBT_MRW_CYCLES);

  typedef struct packed {
    cbt_state_type mode;
    // three-stage pin filter
    cbt_cmd_type s1;
    cbt_cmd_type s2;
    cbt_cmd_type s3;
    cbt_cmd_type pins;
    // strobe toggle crossing
    logic [2:0] tog;
    logic tog_seen;
    cbt_vref_type vref;
    logic [5:0] ca_latched;
    logic [3:0] count;
    logic fsp_saved;
    logic fsp_swapped;
    logic flag;
    cbt_dq_drive_type dq;
    logic ready;
    logic set_point;
  } cbt_state_pack_type;

  cbt_state_pack_type state;
  cbt_state_pack_type next_state;
  cbt_vref_type strobe_word;
  logic strobe_toggle;
  logic strobe_event;
  logic cke_fall;
  logic cke_rise;
  logic cs_rise;
  cbt_cmd_type pins_now;

  cbt_strobe_capture u_strobe (
    .clk_strobe(clk_strobe),
    .rst(rst),
    .dq_in(dq_in[6:0]),
    .word(strobe_word),
    .word_toggle(strobe_toggle)
  );

  // three-stage pin filter: accept when stages two and three agree
  function automatic cbt_cmd_type cbt_filter(input cbt_cmd_type a, input cbt_cmd_type b,
                                             input cbt_cmd_type held);
    if (a == b) begin
      cbt_filter = b;
    end else begin
      cbt_filter = held;
    end
  endfunction

  // training windows in which cke high ends the pattern phase
  function automatic logic cbt_in_window(input cbt_state_type m);
    cbt_in_window = (m == cbt_input) || (m == cbt_gap) || (m == cbt_feedback);
  endfunction

  // filtered pins and their edges
  always_comb begin
    pins_now = cbt_filter(state.s2, state.s3, state.pins);
    cke_fall = state.pins.cke && !pins_now.cke;
    cke_rise = !state.pins.cke && pins_now.cke;
    cs_rise = !state.pins.cs && pins_now.cs;
    strobe_event = (state.tog[1] == state.tog[2]) && (state.tog[2] != state.tog_seen);
  end

  // next state of the whole block
  always_comb begin
    next_state = state;
    next_state.s1 = cmd_pins;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    next_state.pins = pins_now;
    next_state.tog = {state.tog[1:0], strobe_toggle};
    if (state.tog[1] == state.tog[2]) begin
      next_state.tog_seen = state.tog[2];
    end

    // outputs float unless a window below drives them
    next_state.dq.oe = '0;
    next_state.flag = 1'b0;
    if (state.count != '0) begin
      next_state.count = state.count - 4'h1;
    end

    // training window sequencer
    unique case (state.mode)
      // idle: waits for the training enable bit
      cbt_normal: begin
        next_state.ready = 1'b1;
        if (training_enable_bit) begin
          next_state.mode = cbt_armed;
        end
      end

      // enabled: cke low starts training, enable low exits
      cbt_armed: begin
        if (!training_enable_bit) begin
          next_state.mode = cbt_exit;
          next_state.ready = 1'b0;
          next_state.count = MRW_WAIT;
        end else if (cke_fall) begin
          next_state.fsp_saved = active_frequency_set_point_setting;
          next_state.fsp_swapped = 1'b1;
          next_state.mode = cbt_input;
        end
      end

      // strobe input window
      cbt_input: begin
        // dq7 and dmi stay undriven while the strobe samples
        next_state.dq.oe = '0;
        if (strobe_event) begin
          next_state.vref = strobe_word;
          next_state.mode = cbt_gap;
          next_state.count = HIZ_GAP;
        end
      end

      // outputs float before feedback
      cbt_gap: begin
        next_state.dq.oe = '0;
        if (strobe_event) begin
          next_state.vref = strobe_word;
          next_state.count = HIZ_GAP;
        end else if (state.count == '0) begin
          next_state.mode = cbt_feedback;
        end
      end

      // echo of the captured command pins
      cbt_feedback: begin
        next_state.dq.oe = 8'hff;
        next_state.flag = 1'b1;
        next_state.dq.data[`CBT_FLAG_BIT] = ~state.dq.data[`CBT_FLAG_BIT];
        next_state.dq.data[`CBT_VREF_RANGE_BIT] = 1'b0;
        next_state.dq.data[5:0] = state.ca_latched;
        if (cs_rise) begin
          next_state.ca_latched = pins_now.ca;
          next_state.dq.data[5:0] = pins_now.ca;
        end
        if (strobe_event) begin
          next_state.vref = strobe_word;
          next_state.mode = cbt_gap;
          next_state.count = HIZ_GAP;
          next_state.dq.oe = '0;
        end
      end

      // mode write interval before ready
      cbt_exit: begin
        if (state.count == '0) begin
          next_state.mode = cbt_normal;
          next_state.ready = 1'b1;
        end
      end
    endcase

    // cke high leaves any training window
    if (cbt_in_window(state.mode)) begin
      if (cke_rise) begin
        next_state.fsp_swapped = 1'b0;
        next_state.dq.oe = '0;
        next_state.mode = cbt_armed;
      end
    end

    // set point seen by the die, registered with the rest
    next_state.set_point = next_state.fsp_swapped ? ~next_state.fsp_saved : active_frequency_set_point_setting;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.fsp_saved <= `CBT_RESET_FSP;
      // filter starts at the idle pin level, so no false edge follows reset
      state.s1 <= `CBT_PIN_IDLE;
      state.s2 <= `CBT_PIN_IDLE;
      state.s3 <= `CBT_PIN_IDLE;
      state.pins <= `CBT_PIN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from registers, except dmi, which is tied low
  assign dq_drive = state.dq;
  // dmi is left disabled; its input is not used
  assign dmi_out = 1'b0;
  assign dmi_oe = 1'b0;
  assign command_decode_enable = state.pins.cke;
  assign active_frequency_set_point = state.set_point;
  assign ca_reference_voltage = state.vref;
  assign device_ready = state.ready;
endmodule
`default_nettype wire

// ===== rtl/cbt_regs.svh
// constants for the command bus training block
// Function
// - echo captured CA0..CA5 on DQ0..DQ5
// - CKE low stops command decoding
// - CKE low swaps to alternate set point
// - DQ7 disabled during strobe input window
// - DMI pin left disabled in training
// - strobe latches DQ5..0 value, DQ6 range
// - DQ7 toggles in feedback, DQ6 meaningless
// - enable cleared, ready after write interval
// - CKE high restores previous set point
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH
`define CBT_CLK_MHZ 125
`define CBT_CA_WIDTH 6
`define CBT_DQ_WIDTH 8
`define CBT_VREF_RANGE_BIT 6
`define CBT_FLAG_BIT 7
`define CBT_HIZ_GAP_NS 16
`define CBT_HIZ_GAP_CYCLES (((`CBT_HIZ_GAP_NS * `CBT_CLK_MHZ) + 999) / 1000)
`define CBT_MRW_TIME_NS 80
`define CBT_MRW_CYCLES (((`CBT_MRW_TIME_NS * `CBT_CLK_MHZ) + 999) / 1000)
`define CBT_RESET_FSP 1'b0
`define CBT_PIN_IDLE 8'h80
`endif

// ===== rtl/cbt_pkg.sv
// types shared by the command bus training block
`default_nettype none
package cbt_pkg;
  typedef enum logic [2:0] {
    cbt_normal = 3'b000,
    cbt_armed = 3'b001,
    cbt_input = 3'b010,
    cbt_gap = 3'b011,
    cbt_feedback = 3'b100,
    cbt_exit = 3'b101
  } cbt_state_type;

  // two-way pin bundle toward the pads
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } cbt_dq_drive_type;

  // reference voltage code latched by the strobe
  typedef struct packed {
    logic range;
    logic [5:0] value;
  } cbt_vref_type;

  // command pins: cke, cs, ca[5:0]
  typedef struct packed {
    logic cke;
    logic cs;
    logic [5:0] ca;
  } cbt_cmd_type;
endpackage
`default_nettype wire

// ===== rtl/cbt_strobe_capture.sv
// strobe domain capture of the reference voltage code
`include "cbt_regs.svh"
`default_nettype none
module cbt_strobe_capture (
  // strobe clock and reset
  input wire logic clk_strobe,
  input wire logic rst,
  // data pins sampled by the strobe
  input wire logic [6:0] dq_in,
  // accepted word and its toggle event
  output cbt_pkg::cbt_vref_type word,
  output logic word_toggle
);
  import cbt_pkg::*;

  typedef struct packed {
    logic [6:0] last;
    logic have_last;
    cbt_vref_type word;
    logic toggle;
  } cbt_strobe_state_type;

  cbt_strobe_state_type state;
  cbt_strobe_state_type next_state;

  // a word is accepted only when two consecutive pulses agree,
  // so a lost first edge does no harm
  always_comb begin
    next_state = state;
    next_state.last = dq_in;
    next_state.have_last = 1'b1;
    if (state.have_last && state.last == dq_in && state.word != dq_in) begin
      next_state.word = dq_in;
      next_state.toggle = ~state.toggle;
    end
  end

  always_ff @(posedge clk_strobe or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign word = state.word;
  assign word_toggle = state.toggle;
endmodule
`default_nettype wire

// ===== sim/cbt_training_monitor.sv
// assertions on the command bus training block
`default_nettype none
module cbt_training_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire cbt_pkg::cbt_cmd_type cmd_pins,
  input wire logic training_enable_bit,
  input wire logic active_frequency_set_point_setting,
  input wire cbt_pkg::cbt_dq_drive_type dq_drive,
  input wire logic dmi_out,
  input wire logic dmi_oe,
  input wire logic command_decode_enable,
  input wire logic active_frequency_set_point,
  input wire cbt_pkg::cbt_vref_type ca_reference_voltage,
  input wire logic device_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import cbt_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_dmi;
    !dmi_oe && !dmi_out;
  endproperty
  a_dmi: assert property (p_dmi) else $error("dmi driven");
  property p_dq6;
    dq_drive.oe == 8'hff |-> !dq_drive.data[6];
  endproperty
  a_dq6: assert property (p_dq6) else $error("dq6 not zero");
  property p_dq7;
    dq_drive.oe == 8'hff && $past(dq_drive.oe) == 8'hff |->
      dq_drive.data[7] != $past(dq_drive.data[7]);
  endproperty
  a_dq7: assert property (p_dq7) else $error("dq7 not toggling");
  property p_gap;
    $changed(ca_reference_voltage) |-> dq_drive.oe == 8'h00 ##1 dq_drive.oe == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("no hi-z gap");
  property p_dec;
    $fell(cmd_pins.cke) |-> ##[3:5] !command_decode_enable;
  endproperty
  a_dec: assert property (p_dec) else $error("decode still on");
  property p_swap;
    $fell(command_decode_enable) && training_enable_bit |->
      active_frequency_set_point != active_frequency_set_point_setting;
  endproperty
  a_swap: assert property (p_swap) else $error("no set point swap");
  property p_rev;
    $rose(command_decode_enable) |-> ##[0:1] active_frequency_set_point == active_frequency_set_point_setting;
  endproperty
  a_rev: assert property (p_rev) else $error("no set point revert");
  property p_rdy;
    $fell(training_enable_bit) && command_decode_enable |->
      ##[1:2] !device_ready [*8] ##[1:4] device_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("exit wait wrong");
  c_fb: cover property (dq_drive.oe == 8'hff);
  c_swap: cover property ($fell(command_decode_enable));
  c_exit: cover property ($rose(device_ready));
endmodule
bind cbt_training cbt_training_monitor i_cbt_training_monitor (.clk_sys(clk_sys), .rst(rst),
  .cmd_pins(cmd_pins), .training_enable_bit(training_enable_bit),
  .active_frequency_set_point_setting(active_frequency_set_point_setting), .dq_drive(dq_drive), .dmi_out(dmi_out), .dmi_oe(dmi_oe),
  .command_decode_enable(command_decode_enable),
  .active_frequency_set_point(active_frequency_set_point),
  .ca_reference_voltage(ca_reference_voltage), .device_ready(device_ready));
`default_nettype wire

// ===== sim/cbt_ctrl_model.sv
// controller side: strobe bursts carrying a reference voltage word
`default_nettype none
module cbt_ctrl_model (
  // burst request and word
  input wire logic req,
  input wire logic [6:0] word,
  // strobe and data pins
  output logic clk_strobe,
  output logic [6:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    clk_strobe = 0;
    dq = 7'h55;
    forever begin
      @(req);
      #2.3 dq = word;
      repeat (3) begin
        #3 clk_strobe = 1;
        #3 clk_strobe = 0;
      end
      // released lines do not keep the word
      #2 dq = ~word;
    end
  end
endmodule
`default_nettype wire

// ===== sim/cbt_training_tb.sv
// self-checking bench for the command bus training block
`default_nettype none
module cbt_training_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cbt_pkg::*;
  typedef struct packed {logic [6:0] w; logic [5:0] ca;} cbt_row_type;
  cbt_row_type rows [4] = '{'{7'h2a, 6'h15}, '{7'h41, 6'h3f}, '{7'h7f, 6'h00}, '{7'h01, 6'h2a}};
  logic clk_sys = 0, rst = 1, en = 0, fsp = 1, req = 0, clk_strobe, dmi_o, dmi_e, dec, afsp, rdy;
  logic [6:0] word = 0, dq;
  logic ck_run = 1;
  cbt_cmd_type cmd = 8'h80;
  cbt_dq_drive_type drv;
  cbt_vref_type vref;
  int errors = 0, n_compared = 0;
  cbt_training i_cbt_training (.clk_sys(clk_sys), .rst(rst), .clk_strobe(clk_strobe),
    .cmd_pins(cmd), .training_enable_bit(en), .active_frequency_set_point_setting(fsp), .dq_in({1'b0, dq}),
    .dq_drive(drv), .dmi_in(1'b0), .dmi_out(dmi_o), .dmi_oe(dmi_e),
    .command_decode_enable(dec), .active_frequency_set_point(afsp),
    .ca_reference_voltage(vref), .device_ready(rdy));
  cbt_ctrl_model i_cbt_ctrl_model (.req(req), .word(word), .clk_strobe(clk_strobe), .dq(dq));
  initial begin
    forever #4 clk_sys = ck_run & ~clk_sys;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #5000 errors++;
    close_out;
  end
  initial begin
    cyc(6);
    chk("oe_reset", drv.oe, 8'h00);
    chk("ready_reset", rdy, 1'b0);
    cyc(1);
    rst <= 0;
    en <= 1;
    cyc(8);
    chk("ready", rdy, 1'b1);
    cmd.cke <= 0;
    cyc(8);
    chk("decode_off", dec, 1'b0);
    chk("fsp_swap", afsp, !fsp);
    // clock stopped low after the hold time, steady around the stop
    ck_run = 0;
    #42 ck_run = 1;
    cyc(2);
    $display("entry test done");
    foreach (rows[i]) begin
      word <= rows[i].w;
      req <= ~req;
      cyc(12);
      chk("vref", vref, rows[i].w);
      chk("oe_feedback", drv.oe, 8'hff);
      cmd.ca <= rows[i].ca;
      cmd.cs <= 1;
      cyc(3);
      cmd.cs <= 0;
      cyc(8);
      chk("echo", drv.data[5:0], rows[i].ca);
      $display("row %0d done", i);
    end
    cmd.cke <= 1;
    cyc(8);
    chk("fsp_back", afsp, fsp);
    chk("oe_off", drv.oe, 8'h00);
    chk("dmi", {dmi_e, dmi_o}, 2'b00);
    en <= 0;
    cyc(2);
    chk("ready_low", rdy, 1'b0);
    cyc(12);
    chk("ready_back", rdy, 1'b1);
    $display("exit test done");
    close_out;
  end
endmodule
`default_nettype wire
